// ==== verilog/ctp_consts.svh ====
// constants for the cascadable timer pair: register offsets, bit positions,
// reset values and prescaler terminal counts; assumes byte addresses on apb.
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH

// register byte offsets
`define CTP_A_CTRL_LO 8'h00
`define CTP_A_CTRL_HI 8'h04
`define CTP_A_CNT_LO 8'h08
`define CTP_A_CNT_HI 8'h0c
`define CTP_A_PER_LO 8'h10
`define CTP_A_PER_HI 8'h14
`define CTP_A_STAT 8'h18
`define CTP_A_IRQC 8'h1c
`define CTP_A_CNT32 8'h20

// timer_control_word bit positions
`define CTP_B_RUN 15
`define CTP_B_IDLE 13
`define CTP_B_GATE 6
`define CTP_B_PS_HI 5
`define CTP_B_PS_LO 4
`define CTP_B_CHAIN 3
`define CTP_B_CS 1

// writable bits of each control word
`define CTP_CTRL_MASK_LO 16'ha07a
`define CTP_CTRL_MASK_HI 16'ha072

// irq control fields
`define CTP_B_IE_LO 0
`define CTP_B_IE_HI 4

// reset values
`define CTP_CTRL_RST 16'h0000
`define CTP_CNT_RST 16'h0000
`define CTP_PER_RST 16'hffff
`define CTP_IRQC_RST 8'h00

// prescaler terminal counts (ratio minus one)
`define CTP_PS_T1 8'h00
`define CTP_PS_T8 8'h07
`define CTP_PS_T64 8'h3f
`define CTP_PS_T256 8'hff

`endif

// ==== verilog/ctp_pkg.sv ====
// types for the cascadable timer pair: mode codes and the state record;
// assumes ctp_consts.svh supplies all numeric constants.
package ctp_pkg;

	// count clock selection decoded from source and gate bits
	typedef enum logic [1:0] {
		CTP_TIMER = 2'b00,
		CTP_GATED = 2'b01,
		CTP_COUNTER = 2'b10
	} ctp_mode_t;

	// whole state of the pair, index 0 = lower word, 1 = upper word
	typedef struct packed {
		logic [1:0][15:0] ctrl; // control words
		logic [1:0][15:0] cnt; // count registers
		logic [1:0][15:0] per; // period registers
		logic [1:0] flag; // sticky period flags
		logic [7:0] irqc; // enables and priorities
		logic [1:0] sa; // synchroniser first stage
		logic [1:0] sb; // synchroniser second stage
		logic [1:0] sc; // edge history after sync
		logic [1:0] raw; // previous pin levels
		logic tg; // lower prescaler output toggle
		logic [1:0][7:0] psc; // prescaler counters
		logic pready; // apb ready
		logic pslverr; // apb error
		logic [31:0] prdata; // apb read data
		logic [1:0] irq; // interrupt requests
		logic adc; // conversion trigger pulse
		logic dma_lo; // lower dma request pulse
		logic dma_hi; // upper dma request pulse
	} ctp_state_t;

endpackage

// ==== verilog/ctp_timer_pair.sv ====
// one lower-word / upper-word timer pair with an apb register file.
// assumes pins synchronous to MCLK_I, which is the instruction clock.
`timescale 1ns/100ps
`include "ctp_consts.svh"

// Summary of operation
// RULE1 - lower and upper timers chain as 32-bit
// RULE2 - lower pin synchronised after its prescaler
// RULE3 - upper pin synchronised before its prescaler
// RULE4 - upper timer drives conversion trigger pulse
// RULE5 - timer and gated modes count instruction clock
// RULE6 - counter mode counts external pin edges
// RULE7 - source and gate bits pick mode
// RULE8 - software setup order for 16-bit use
// RULE9 - only first pair issues dma requests
// RULE10 - chain bit set means 32-bit mode
// RULE11 - upper holds high word, lower low
// RULE12 - chained: lower controls, upper idle kept
// RULE13 - chained: upper interrupt controls only
// RULE14 - pairs fixed: instance index picks pair
// RULE15 - chained prescale from lower select bits
// RULE16 - 32-bit period is upper:lower periods
// RULE17 - 32-bit count readable as register pair
// RULE18 - prescale codes divide 1, 8, 64, 256
// RULE19 - run bit starts and stops timer
// RULE20 - idle halt bit stops timer in idle
// RULE21 - match period: wrap to zero, flag
// RULE22 - gated: count while high, flag on fall
module ctp_timer_pair #(
	parameter int PAIR_INDEX = 0, // 0 = first pair, 1 = second pair
	parameter bit ADC_TRIG_EN = 1'b1 // pair feeds the converter trigger
) (
	input wire logic MCLK_I, // 10 MHz instruction clock
	input wire logic RESET_I, // async reset, active high
	input wire logic PSEL_I, // apb select
	input wire logic PENABLE_I, // apb enable
	input wire logic PWRITE_I, // apb direction
	input wire logic [7:0] PADDR_I, // apb byte address
	input wire logic [31:0] PWDATA_I, // apb write data
	output logic [31:0] PRDATA_O, // apb read data
	output logic PREADY_O, // apb ready
	output logic PSLVERR_O, // apb error
	input wire logic [1:0] EXT_CNT_I, // external count/gate pins
	input wire logic IDLE_I, // device idle mode
	output logic [1:0] IRQ_O, // interrupt requests lo/hi
	output logic [2:0] IRQ_PRI_LO_O, // lower priority
	output logic [2:0] IRQ_PRI_HI_O, // upper priority
	output logic ADC_TRIG_O, // conversion start pulse
	output logic DMA_REQ_LO_O, // lower dma request pulse
	output logic DMA_REQ_HI_O // upper dma request pulse
);

	ctp_pkg::ctp_state_t q; // registered state
	ctp_pkg::ctp_state_t n; // next state
	logic [1:0] tick_c; // counter advance per timer
	logic [1:0] fall_c; // gate falling edge per timer
	logic [1:0] gated_c; // timer is in gated mode
	logic chain_c; // 32-bit mode
	logic bus_wr_c; // write takes effect now

	// next state: prescalers, counters, flags and the apb slave
	always_comb begin
		logic [15:0] c;
		logic halt;
		logic run;
		logic pin_in;
		logic wrap;
		logic [7:0] term;
		logic [1:0] set;
		logic [1:0] clr;
		logic acc;
		logic hit;
		logic [31:0] rd;
		ctp_pkg::ctp_mode_t mode;
		c = 16'h0000;
		halt = 1'b0;
		run = 1'b0;
		pin_in = 1'b0;
		wrap = 1'b0;
		term = `CTP_PS_T1;
		set = 2'b00;
		clr = 2'b00;
		acc = 1'b0;
		rd = 32'h0000_0000;
		hit = 1'b1;
		mode = ctp_pkg::CTP_TIMER;
		n = q;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.adc = 1'b0;
		n.dma_lo = 1'b0;
		n.dma_hi = 1'b0;
		tick_c = 2'b00;
		fall_c = 2'b00;
		gated_c = 2'b00;
		chain_c = q.ctrl[0][`CTP_B_CHAIN]; // [RULE10]
		// lower path syncs its prescaler toggle, upper path its pin
		n.sa = {EXT_CNT_I[1], q.tg}; // [RULE2] [RULE3]
		n.sb = q.sa;
		n.sc = q.sb;
		n.raw = EXT_CNT_I;

		// per timer: mode, prescaler and count clock
		for (int i = 0; i < 2; i++) begin
			// chained pair takes the lower control word
			c = chain_c ? q.ctrl[0] : q.ctrl[i]; // [RULE12] [RULE15]
			// chained: either idle bit halts, the upper one is honoured
			halt = IDLE_I & (chain_c ? (q.ctrl[0][`CTP_B_IDLE] | q.ctrl[1][`CTP_B_IDLE])
				: q.ctrl[i][`CTP_B_IDLE]); // [RULE20] [RULE12]
			run = c[`CTP_B_RUN] & ~halt; // [RULE19]
			if (c[`CTP_B_CS]) begin
				mode = ctp_pkg::CTP_COUNTER; // gate bit ignored [RULE7]
			end else if (c[`CTP_B_GATE]) begin
				mode = ctp_pkg::CTP_GATED; // [RULE7]
			end else begin
				mode = ctp_pkg::CTP_TIMER; // [RULE7]
			end
			gated_c[i] = (mode == ctp_pkg::CTP_GATED);
			case (c[`CTP_B_PS_HI:`CTP_B_PS_LO])
				2'b11: term = `CTP_PS_T256; // [RULE18]
				2'b10: term = `CTP_PS_T64; // [RULE18]
				2'b01: term = `CTP_PS_T8; // [RULE18]
				default: term = `CTP_PS_T1; // [RULE18]
			endcase
			// prescaler input event
			case (mode)
				ctp_pkg::CTP_COUNTER: begin
					// lower counts raw pin edges, upper counts synced edges
					pin_in = (i == 0) ? (EXT_CNT_I[0] & ~q.raw[0])
						: (q.sb[1] & ~q.sc[1]); // [RULE6] [RULE3]
				end
				ctp_pkg::CTP_GATED: pin_in = EXT_CNT_I[i]; // [RULE22] [RULE5]
				default: pin_in = 1'b1; // instruction clock [RULE5]
			endcase
			wrap = 1'b0;
			if (run & pin_in) begin
				// >= copes with a ratio lowered mid-count
				if (q.psc[i] >= term) begin
					n.psc[i] = 8'h00;
					wrap = 1'b1;
				end else begin
					n.psc[i] = q.psc[i] + 8'h01;
				end
			end
			if (i == 0 && mode == ctp_pkg::CTP_COUNTER) begin
				// prescaler output crosses as a toggle: costs three cycles of lag
				if (wrap) begin
					n.tg = ~q.tg; // [RULE2]
				end
				tick_c[0] = run & (q.sb[0] ^ q.sc[0]); // [RULE2]
			end else begin
				tick_c[i] = wrap;
			end
			fall_c[i] = run & gated_c[i] & q.raw[i] & ~EXT_CNT_I[i]; // [RULE22]
		end

		// counters
		if (chain_c) begin
			// upper is high word, lower low word [RULE1] [RULE11]
			if (tick_c[0]) begin
				if ({q.cnt[1], q.cnt[0]} == {q.per[1], q.per[0]}) begin // [RULE16]
					n.cnt[1] = `CTP_CNT_RST; // [RULE21]
					n.cnt[0] = `CTP_CNT_RST;
					set[1] = ~gated_c[0]; // upper flag serves the pair [RULE13]
				end else begin
					{n.cnt[1], n.cnt[0]} = {q.cnt[1], q.cnt[0]} + 32'h0000_0001; // [RULE11]
				end
			end
			set[1] = set[1] | fall_c[0]; // [RULE22] [RULE13]
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (tick_c[i]) begin
					if (q.cnt[i] == q.per[i]) begin
						n.cnt[i] = `CTP_CNT_RST; // [RULE21]
						set[i] = ~gated_c[i]; // [RULE21]
					end else begin
						n.cnt[i] = q.cnt[i] + 16'h0001; // [RULE21]
					end
				end
				set[i] = set[i] | fall_c[i]; // [RULE22]
			end
		end

		// trigger and dma pulses; dma exists on the first pair only
		n.adc = ADC_TRIG_EN & set[1]; // [RULE4]
		n.dma_lo = (PAIR_INDEX == 0) & set[0]; // [RULE9] [RULE14]
		n.dma_hi = (PAIR_INDEX == 0) & set[1]; // [RULE9] [RULE14]

		// apb: one wait state, answer registered in the first access cycle
		acc = PSEL_I & PENABLE_I & ~q.pready;
		bus_wr_c = PSEL_I & PENABLE_I & q.pready & PWRITE_I;
		case (PADDR_I)
			`CTP_A_CTRL_LO: rd = {16'h0000, q.ctrl[0]};
			`CTP_A_CTRL_HI: rd = {16'h0000, q.ctrl[1]};
			`CTP_A_CNT_LO: rd = {16'h0000, q.cnt[0]};
			`CTP_A_CNT_HI: rd = {16'h0000, q.cnt[1]};
			`CTP_A_PER_LO: rd = {16'h0000, q.per[0]};
			`CTP_A_PER_HI: rd = {16'h0000, q.per[1]};
			`CTP_A_STAT: rd = {30'h0000_0000, q.flag};
			`CTP_A_IRQC: rd = {24'h00_0000, q.irqc};
			`CTP_A_CNT32: rd = {q.cnt[1], q.cnt[0]}; // [RULE17]
			default: hit = 1'b0; // unmapped: error, zero data
		endcase
		if (acc) begin
			n.pready = 1'b1;
			n.prdata = rd;
			n.pslverr = ~hit;
		end
		// writes land at the edge where pready is seen high
		if (bus_wr_c) begin
			case (PADDR_I)
				`CTP_A_CTRL_LO: n.ctrl[0] = PWDATA_I[15:0] & `CTP_CTRL_MASK_LO;
				`CTP_A_CTRL_HI: n.ctrl[1] = PWDATA_I[15:0] & `CTP_CTRL_MASK_HI;
				`CTP_A_CNT_LO: n.cnt[0] = PWDATA_I[15:0]; // write beats a tick
				`CTP_A_CNT_HI: n.cnt[1] = PWDATA_I[15:0];
				`CTP_A_PER_LO: n.per[0] = PWDATA_I[15:0];
				`CTP_A_PER_HI: n.per[1] = PWDATA_I[15:0];
				`CTP_A_STAT: clr = PWDATA_I[1:0]; // write one to clear
				`CTP_A_IRQC: n.irqc = PWDATA_I[7:0];
				default: clr = 2'b00; // ignored
			endcase
		end
		// a flag set in the clearing cycle survives
		n.flag = (q.flag & ~clr) | set;
		// chained: lower interrupt suppressed [RULE13]
		n.irq[0] = n.flag[0] & n.irqc[`CTP_B_IE_LO] & ~n.ctrl[0][`CTP_B_CHAIN];
		n.irq[1] = n.flag[1] & n.irqc[`CTP_B_IE_HI]; // [RULE13]
	end

	// state register
	always_ff @(posedge MCLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			q <= '0;
			q.ctrl <= {`CTP_CTRL_RST, `CTP_CTRL_RST};
			q.cnt <= {`CTP_CNT_RST, `CTP_CNT_RST};
			q.per <= {`CTP_PER_RST, `CTP_PER_RST};
			q.irqc <= `CTP_IRQC_RST;
		end else begin
			q <= n;
		end
	end

	// outputs straight from the state register
	assign PRDATA_O = q.prdata;
	assign PREADY_O = q.pready;
	assign PSLVERR_O = q.pslverr;
	assign IRQ_O = q.irq;
	assign IRQ_PRI_LO_O = q.irqc[3:1];
	assign IRQ_PRI_HI_O = q.irqc[7:5];
	assign ADC_TRIG_O = q.adc;
	assign DMA_REQ_LO_O = q.dma_lo;
	assign DMA_REQ_HI_O = q.dma_hi;

	// checks
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);

	// chained mode never raises the lower interrupt
	property p_chain_irq;
		chain_c |-> !IRQ_O[0];
	endproperty
	a_chain_irq: assert property (p_chain_irq) else $error("lower irq while chained"); // [RULE13]

	// stopped lower timer holds its count
	property p_stop_hold;
		(!chain_c && !q.ctrl[0][`CTP_B_RUN] && !bus_wr_c) |=> $stable(q.cnt[0]);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped"); // [RULE19]

	// idle halt freezes the upper counter
	property p_idle_hold;
		(!chain_c && IDLE_I && q.ctrl[1][`CTP_B_IDLE] && !bus_wr_c) |=> $stable(q.cnt[1]);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("count moved in idle"); // [RULE20]

	// internal 1:1 counting increments every cycle
	sequence s_free_lo;
		!chain_c && q.ctrl[0][`CTP_B_RUN] && !IDLE_I && q.ctrl[0][6:4] == 3'b000
			&& !q.ctrl[0][`CTP_B_CS] && q.psc[0] == 8'h00;
	endsequence
	property p_inc_lo;
		(s_free_lo and (q.cnt[0] != q.per[0] && !bus_wr_c))
			|=> q.cnt[0] == $past(q.cnt[0]) + 16'h0001;
	endproperty
	a_inc_lo: assert property (p_inc_lo) else $error("lower did not count"); // [RULE5]

	// period match wraps to zero and raises the flag
	property p_wrap_lo;
		(s_free_lo and (q.cnt[0] == q.per[0] && !bus_wr_c))
			|=> q.cnt[0] == 16'h0000 && q.flag[0];
	endproperty
	a_wrap_lo: assert property (p_wrap_lo) else $error("no wrap at period"); // [RULE21]

	// internal 1:8 prescale holds count until counter reaches 7
	// external source left out: its synced tick lags the prescaler wrap
	property p_ps8;
		(!chain_c && !q.ctrl[0][`CTP_B_CS] && q.ctrl[0][5:4] == 2'b01 && q.psc[0] < 8'h07
			&& !bus_wr_c)
			|=> $stable(q.cnt[0]);
	endproperty
	a_ps8: assert property (p_ps8) else $error("1:8 prescale counted early"); // [RULE18]

	// 1:256 prescale on the upper timer
	property p_ps256;
		(!chain_c && q.ctrl[1][5:4] == 2'b11 && q.psc[1] < 8'hff && !bus_wr_c)
			|=> $stable(q.cnt[1]);
	endproperty
	a_ps256: assert property (p_ps256) else $error("1:256 prescale counted early"); // [RULE18]

	// gate low stops a gated count
	property p_gate_low;
		(gated_c[0] && !chain_c && !EXT_CNT_I[0] && q.psc[0] == 8'h00 && !bus_wr_c)
			|=> $stable(q.cnt[0]);
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("gated count with gate low"); // [RULE22]

	// gate fall raises the flag one cycle later
	property p_gate_fall;
		fall_c[0] && !chain_c |=> q.flag[0];
	endproperty
	a_gate_fall: assert property (p_gate_fall) else $error("no flag on gate fall"); // [RULE22]

	// chained carry from lower into upper word
	property p_carry;
		(chain_c && tick_c[0] && q.cnt[0] == 16'hffff && !bus_wr_c
			&& {q.cnt[1], q.cnt[0]} != {q.per[1], q.per[0]})
			|=> q.cnt[0] == 16'h0000 && q.cnt[1] == $past(q.cnt[1]) + 16'h0001;
	endproperty
	a_carry: assert property (p_carry) else $error("no carry into upper word"); // [RULE11]

	// upper pin edge shows as a synced edge two cycles after the pin rises
	sequence s_hi_edge;
		!EXT_CNT_I[1] ##1 EXT_CNT_I[1];
	endsequence
	property p_hi_sync;
		((!chain_c && q.ctrl[1][`CTP_B_CS]) ##0 s_hi_edge)
			|=> ##1 (q.sb[1] && !q.sc[1]);
	endproperty
	a_hi_sync: assert property (p_hi_sync) else $error("upper sync path broken"); // [RULE3]

	// conversion trigger pulses with the upper flag set
	property p_adc;
		ADC_TRIG_O |-> q.flag[1];
	endproperty
	a_adc: assert property (p_adc) else $error("trigger without upper flag"); // [RULE4]

	// apb answers one cycle into the access phase
	property p_apb;
		(PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O ##1 !PREADY_O;
	endproperty
	a_apb: assert property (p_apb) else $error("apb ready timing wrong");

endmodule

// ==== dv/ctp_pin_model.sv ====
// drives the external count/gate pins of the timer pair.
// assumes the bench calls pulse from its main sequence, one call at a time.
`timescale 1ns/100ps
module ctp_pin_model (
	input wire logic clk_i, // bench clock
	output logic [1:0] pin_o // external count/gate pins
);
	// pins rest low between pulses, as an undriven gate would
	initial begin
		pin_o = 2'b00;
	end
	// n pulses on the chosen pins, len cycles low then len cycles high
	task automatic pulse(input logic [1:0] ch, input int n, input int len);
		repeat (n) begin
			repeat (len) @(posedge clk_i);
			pin_o <= ch;
			repeat (len) @(posedge clk_i);
			pin_o <= 2'b00;
		end
	endtask
endmodule

// ==== dv/cascadable_timer_pair_test.sv ====
// self-checking bench for the timer pair: apb master, read scoreboard, pulse timing.
// assumes one wait state per apb transfer and the pin model beside the dut.
`timescale 1ns/100ps
`include "ctp_consts.svh"
module cascadable_timer_pair_test;
	logic mclk = 1'b0; // 10 MHz clock
	logic rst = 1'b1; // active high reset
	logic psel = 1'b0, penable = 1'b0, pwr = 1'b0; // apb controls
	logic [7:0] paddr = 8'h00; // apb address
	logic [31:0] pwdata = 32'h00000000; // apb write data
	logic [31:0] prdata; // apb read data
	logic pready, pslverr; // apb answer
	logic [1:0] ext; // pin model output
	logic idle = 1'b0; // device idle
	logic [1:0] irq; // interrupt levels
	logic [2:0] pri_lo, pri_hi; // priorities
	logic adc, dma_lo, dma_hi; // event pulses
	logic [32:0] exp_q[$]; // expected {error, data} per read
	logic [32:0] e; // note under comparison
	logic [31:0] rnd = 32'hdfa04cdd; // xorshift state
	int err_count = 0; // mismatches
	int checks_done = 0; // comparisons
	always #50 mclk = ~mclk;
	ctp_timer_pair dut_u (.MCLK_I(mclk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_CNT_I(ext), .IDLE_I(idle),
		.IRQ_O(irq), .IRQ_PRI_LO_O(pri_lo), .IRQ_PRI_HI_O(pri_hi), .ADC_TRIG_O(adc),
		.DMA_REQ_LO_O(dma_lo), .DMA_REQ_HI_O(dma_hi));
	ctp_pin_model pin_u (.clk_i(mclk), .pin_o(ext));
	// verdict, the only exit of the run
	task automatic final_report();
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// case-equality compare with one report line on mismatch
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// one apb transfer; an idle cycle after it so no signal is set twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			final_report();
		end
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// reads note their expectation, the monitor compares
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h00000000);
	endtask
	function automatic logic sig(input int s);
		return (s == 0) ? dma_lo : (s == 1) ? dma_hi : adc;
	endfunction
	// cycles between two successive pulses of an event output
	task automatic gap(input int s, input int x);
		int n;
		int t;
		n = 0;
		while (sig(s) !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		t = 1;
		while (sig(s) !== 1'b1 && t < 3000) begin
			@(posedge mclk);
			t++;
		end
		chk("pulse gap", x, t);
		if (n >= 3000 || t >= 3000) begin
			err_count++;
			final_report();
		end
	endtask
	// read answers taken off the queue at the completing edge
	always @(posedge mclk) begin
		if (psel && penable && !pwr && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("read note", 32'h1, 32'h0);
			end else begin
				e = exp_q.pop_front();
				chk("prdata", e[31:0], prdata);
				chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			end
		end
	end
	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(`CTP_A_CTRL_LO, 33'h0);
		rd(`CTP_A_PER_LO, 33'h0ffff);
		rd(`CTP_A_IRQC, 33'h0);
		rd(8'h24, 33'h100000000);
		// every prescale code, period 1: two ticks per period
		for (int c = 0; c < 4; c++) begin
			wr(`CTP_A_CTRL_LO, c << 4);
			wr(`CTP_A_PER_LO, 32'h1);
			wr(`CTP_A_IRQC, 32'h1);
			wr(`CTP_A_CTRL_LO, 32'h8000 | (c << 4));
			gap(0, 2 << (3 * c - (c == 3 ? 1 : 0)));
		end
		rd(`CTP_A_STAT, 33'h1);
		chk("irq", 32'h1, {30'h0, irq});
		// chained pair, period {0,3}; upper control word loaded with junk
		wr(`CTP_A_CTRL_LO, 32'h0);
		wr(`CTP_A_STAT, 32'h3);
		wr(`CTP_A_CTRL_HI, 32'h8072);
		wr(`CTP_A_PER_HI, 32'h0);
		wr(`CTP_A_PER_LO, 32'h3);
		wr(`CTP_A_IRQC, 32'hb5);
		wr(`CTP_A_CTRL_LO, 32'h8008);
		gap(2, 4);
		gap(1, 4);
		chk("irq", 32'h2, {30'h0, irq});
		chk("pri", 32'h52, {24'h0, 1'b0, pri_hi, 1'b0, pri_lo});
		// carry out of the low word lands in the upper count
		wr(`CTP_A_CTRL_LO, 32'h8);
		wr(`CTP_A_CNT_LO, 32'hffff);
		wr(`CTP_A_CNT_HI, 32'h0);
		wr(`CTP_A_PER_HI, 32'h2);
		wr(`CTP_A_PER_LO, 32'h0);
		wr(`CTP_A_CTRL_LO, 32'h8008);
		wr(`CTP_A_CTRL_LO, 32'h8);
		rd(`CTP_A_CNT_HI, 33'h1);
		rnd = xs(rnd);
		wr(`CTP_A_CNT_LO, {16'h0, rnd[15:0]});
		wr(`CTP_A_CNT_HI, {16'h0, rnd[31:16]});
		rd(`CTP_A_CNT32, {1'b0, rnd});
		// idle: halts with the halt bit, runs without it
		wr(`CTP_A_CTRL_LO, 32'ha000);
		idle <= 1'b1;
		wr(`CTP_A_CNT_LO, 32'h0);
		repeat (20) @(posedge mclk);
		rd(`CTP_A_CNT_LO, 33'h0);
		wr(`CTP_A_PER_LO, 32'h1);
		wr(`CTP_A_CTRL_LO, 32'h8000);
		gap(0, 2);
		idle <= 1'b0;
		// counter mode on both timers, gate bit set but ignored
		wr(`CTP_A_CTRL_LO, 32'h0);
		wr(`CTP_A_CNT_LO, 32'h0);
		wr(`CTP_A_PER_LO, 32'hffff);
		wr(`CTP_A_CNT_HI, 32'h0);
		wr(`CTP_A_PER_HI, 32'hffff);
		wr(`CTP_A_CTRL_LO, 32'h8042);
		wr(`CTP_A_CTRL_HI, 32'h8042);
		pin_u.pulse(2'b11, 3, 4);
		repeat (10) @(posedge mclk);
		rd(`CTP_A_CNT_LO, 33'h3);
		rd(`CTP_A_CNT_HI, 33'h3);
		// gated mode: flag set when the gate falls
		wr(`CTP_A_CTRL_LO, 32'h0);
		wr(`CTP_A_STAT, 32'h3);
		wr(`CTP_A_CTRL_LO, 32'h8040);
		pin_u.pulse(2'b01, 1, 10);
		repeat (8) @(posedge mclk);
		rd(`CTP_A_STAT, 33'h1);
		rd(`CTP_A_CNT_LO, 33'hd);
		// mid-run reset brings every register back
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(`CTP_A_CTRL_HI, 33'h0);
		rd(`CTP_A_PER_HI, 33'h0ffff);
		rd(`CTP_A_STAT, 33'h0);
		chk("irq", 32'h0, {30'h0, irq});
		@(posedge mclk);
		chk("notes left", 32'h0, exp_q.size());
		final_report();
	end
endmodule
